// [shared/slsub_pkg.sv]
// slsub_pkg: constants for the power-down and literal-subtract execution block
package slsub_pkg;
	// ----------------------------------------------------------------
	// instruction encodings (14-bit)
	// ----------------------------------------------------------------
	localparam logic [13:0] SLSUB_OP_SLEEP = 14'h0063;
	localparam logic [13:0] SLSUB_LITERAL_MINUS_W_INSTR_MASK = 14'h3e00;
	localparam logic [13:0] SLSUB_LITERAL_MINUS_W_INSTR_MATCH = 14'h3c00;
	localparam int SLSUB_LIT_MSB = 7;
	// ----------------------------------------------------------------
	// wishbone register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] SLSUB_REG_CTRL = 8'h00;
	localparam logic [7:0] SLSUB_REG_INSTR = 8'h04;
	localparam logic [7:0] SLSUB_REG_STATUS = 8'h08;
	localparam logic [7:0] SLSUB_REG_W = 8'h0c;
	localparam logic [7:0] SLSUB_REG_IRQ_STAT = 8'h10;
	localparam logic [7:0] SLSUB_REG_IRQ_MASK = 8'h14;
	localparam logic [7:0] SLSUB_REG_WDT = 8'h18;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int SLSUB_ST_C = 0;
	localparam int SLSUB_ST_DC = 1;
	localparam int SLSUB_ST_Z = 2;
	localparam int SLSUB_ST_PD = 3;
	localparam int SLSUB_ST_TO = 4;
	localparam int SLSUB_ST_SLEEP = 5;
	localparam int SLSUB_CTRL_WAKE = 0;
	localparam int SLSUB_CTRL_WDT_TICK = 1;
	localparam int SLSUB_IRQ_SLEEP = 0;
	localparam int SLSUB_IRQ_SUB = 1;
	localparam int SLSUB_IRQ_BAD = 2;
	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] SLSUB_W_RST = 8'h00;
	localparam logic [7:0] SLSUB_WDT_RST = 8'h00;
	localparam logic [7:0] SLSUB_PRE_RST = 8'h00;
	localparam logic [2:0] SLSUB_IRQ_RST = 3'h0;
	// ----------------------------------------------------------------
	// states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {SLSUB_IDLE, SLSUB_Q1, SLSUB_Q2, SLSUB_Q3, SLSUB_Q4,
		SLSUB_ASLEEP} slsub_state_e;
endpackage

// [rtl/slsub_subtract.sv]
// slsub_subtract: literal minus working register with carry, digit carry, zero
`timescale 1ns/100ps
module slsub_subtract
	import slsub_pkg::*;
(
	input wire logic [7:0] lit,
	input wire logic [7:0] w_in,
	output logic [7:0] diff,
	output logic carry,
	output logic dcarry,
	output logic zero
);
	logic [8:0] full;
	logic [4:0] low;
	always_comb begin
		// two's complement: k + ~w + 1, carry is no-borrow
		full = {1'b0, lit} + {1'b0, ~w_in} + 9'h001; // RL6
		low = {1'b0, lit[3:0]} + {1'b0, ~w_in[3:0]} + 5'h01; // RL6
		diff = full[7:0];
		carry = full[8];
		dcarry = low[4];
		zero = (full[7:0] == 8'h00);
	end
endmodule

// [rtl/slsub_exec.sv]
// slsub_exec: power-down and literal-subtract execution with wishbone registers
//
// Our own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
// Functional notes
// (RL1) power-down instruction clears power-down flag
// (RL2) power-down instruction sets time-out flag
// (RL3) power-down clears watchdog and its prescaler
// (RL4) four phases, sleep entered in fourth
// (RL5) oscillator held stopped while asleep
// (RL6) literal minus w, updates c, dc, z
module slsub_exec
	import slsub_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq_o,
	output logic osc_run_o,
	output logic sleep_o
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	slsub_state_e state_q, state_d;
	logic [13:0] instr_q, instr_d;
	logic [7:0] w_q, w_d;
	logic [7:0] watchdog_counter_q, watchdog_counter_d;
	logic [7:0] pre_q, pre_d;
	logic powerdown_flag_n_q, powerdown_flag_n_d;
	logic timeout_flag_n_q, timeout_flag_n_d;
	logic carry_q, carry_d;
	logic digit_carry_flag_q, digit_carry_flag_d;
	logic zero_q, zero_d;
	logic [2:0] irq_stat_q, irq_stat_d;
	logic [2:0] irq_mask_q, irq_mask_d;
	logic [31:0] dat_q, dat_d;
	logic ack_q, ack_d;
	logic irq_q, irq_d;
	logic osc_q, osc_d;
	logic sleep_q, sleep_d;
	logic [7:0] sub_diff;
	logic sub_c, sub_dc, sub_z;
	logic is_sleep, is_sub;
	logic [2:0] ev;
	logic wr, rd;
	logic wr_ctrl, wr_instr, wr_w, wr_stat, wr_mask;
	logic wake_req, tick_req;
	logic idle;

	slsub_subtract u_sub (
		.lit(instr_q[SLSUB_LIT_MSB:0]),
		.w_in(w_q),
		.diff(sub_diff),
		.carry(sub_c),
		.dcarry(sub_dc),
		.zero(sub_z)
	);

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	assign is_sleep = (instr_q == SLSUB_OP_SLEEP);
	assign is_sub = ((instr_q & SLSUB_LITERAL_MINUS_W_INSTR_MASK) == SLSUB_LITERAL_MINUS_W_INSTR_MATCH);
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
	assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q;
	assign idle = (state_q == SLSUB_IDLE);
	// writes to the instruction and w registers are dropped while busy or asleep
	// an opcode spans two byte lanes, so both must be enabled
	assign wr_ctrl = wr && (wb_adr_i == SLSUB_REG_CTRL) && wb_sel_i[0];
	assign wr_instr = wr && (wb_adr_i == SLSUB_REG_INSTR) && (wb_sel_i[1:0] == 2'h3) && idle;
	assign wr_w = wr && (wb_adr_i == SLSUB_REG_W) && wb_sel_i[0] && idle;
	assign wr_stat = wr && (wb_adr_i == SLSUB_REG_IRQ_STAT) && wb_sel_i[0];
	assign wr_mask = wr && (wb_adr_i == SLSUB_REG_IRQ_MASK) && wb_sel_i[0];
	assign wake_req = wr_ctrl && wb_dat_i[SLSUB_CTRL_WAKE];
	assign tick_req = wr_ctrl && wb_dat_i[SLSUB_CTRL_WDT_TICK];

	// ----------------------------------------------------------------
	// instruction sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		instr_d = instr_q;
		w_d = w_q;
		powerdown_flag_n_d = powerdown_flag_n_q;
		timeout_flag_n_d = timeout_flag_n_q;
		carry_d = carry_q;
		digit_carry_flag_d = digit_carry_flag_q;
		zero_d = zero_q;
		ev = 3'h0;
		if (wr_w) begin
			w_d = wb_dat_i[7:0];
		end
		unique case (state_q)
			SLSUB_IDLE: begin
				if (wr_instr) begin
					instr_d = wb_dat_i[13:0];
					state_d = SLSUB_Q1; // RL4
				end
			end
			SLSUB_Q1: begin
				state_d = SLSUB_Q2; // RL4
			end
			SLSUB_Q2: begin
				state_d = SLSUB_Q3; // RL4
			end
			SLSUB_Q3: begin
				state_d = SLSUB_Q4; // RL4
			end
			SLSUB_Q4: begin
				state_d = SLSUB_IDLE;
				if (is_sleep) begin
					powerdown_flag_n_d = 1'b0; // RL1
					timeout_flag_n_d = 1'b1; // RL2
					state_d = SLSUB_ASLEEP; // RL4
					ev[SLSUB_IRQ_SLEEP] = 1'b1;
				end else if (is_sub) begin
					w_d = sub_diff; // RL6
					carry_d = sub_c; // RL6
					digit_carry_flag_d = sub_dc; // RL6
					zero_d = sub_z; // RL6
					ev[SLSUB_IRQ_SUB] = 1'b1;
				end else begin
					// other opcodes belong to other blocks; flagged, no effect
					ev[SLSUB_IRQ_BAD] = 1'b1;
				end
			end
			SLSUB_ASLEEP: begin
				// only a wake write leaves; execution stays halted otherwise
				if (wake_req) begin
					state_d = SLSUB_IDLE;
				end
			end
			default: begin
				state_d = SLSUB_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= SLSUB_IDLE;
			instr_q <= 14'h0000;
			w_q <= SLSUB_W_RST;
			powerdown_flag_n_q <= 1'b1;
			timeout_flag_n_q <= 1'b1;
			carry_q <= 1'b0;
			digit_carry_flag_q <= 1'b0;
			zero_q <= 1'b0;
		end else begin
			state_q <= state_d;
			instr_q <= instr_d;
			w_q <= w_d;
			powerdown_flag_n_q <= powerdown_flag_n_d;
			timeout_flag_n_q <= timeout_flag_n_d;
			carry_q <= carry_d;
			digit_carry_flag_q <= digit_carry_flag_d;
			zero_q <= zero_d;
		end
	end

	// ----------------------------------------------------------------
	// watchdog stand-in
	// ----------------------------------------------------------------
	// a software tick stands in for the real watchdog so the clear is observable
	always_comb begin
		watchdog_counter_d = watchdog_counter_q;
		pre_d = pre_q;
		// a tick in the sleep-entry cycle is lost to the clear
		if (state_q == SLSUB_Q4 && is_sleep) begin
			watchdog_counter_d = SLSUB_WDT_RST; // RL3
			pre_d = SLSUB_PRE_RST; // RL3
		end else if (tick_req) begin
			pre_d = pre_q + 8'h01;
			if (pre_q == 8'hff) begin
				watchdog_counter_d = watchdog_counter_q + 8'h01;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			watchdog_counter_q <= SLSUB_WDT_RST;
			pre_q <= SLSUB_PRE_RST;
		end else begin
			watchdog_counter_q <= watchdog_counter_d;
			pre_q <= pre_d;
		end
	end

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	always_comb begin
		irq_mask_d = irq_mask_q;
		irq_stat_d = irq_stat_q;
		if (wr_mask) begin
			irq_mask_d = wb_dat_i[2:0];
		end
		// set beats write-one-to-clear in the same cycle
		if (wr_stat) begin
			irq_stat_d = irq_stat_q & ~wb_dat_i[2:0];
		end
		irq_stat_d = irq_stat_d | ev;
		// level follows the next values, so it rises on the event edge
		irq_d = |(irq_stat_d & irq_mask_d);
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_stat_q <= SLSUB_IRQ_RST;
			irq_mask_q <= SLSUB_IRQ_RST;
			irq_q <= 1'b0;
		end else begin
			irq_stat_q <= irq_stat_d;
			irq_mask_q <= irq_mask_d;
			irq_q <= irq_d;
		end
	end

	// ----------------------------------------------------------------
	// bus response
	// ----------------------------------------------------------------
	// no request is taken while ack stands, so a request dropped with ack acts once
	always_comb begin
		ack_d = wr || rd;
		dat_d = 32'h00000000;
		if (rd) begin
			unique case (wb_adr_i)
				SLSUB_REG_INSTR: begin
					dat_d = {18'h00000, instr_q};
				end
				SLSUB_REG_STATUS: begin
					dat_d[SLSUB_ST_C] = carry_q;
					dat_d[SLSUB_ST_DC] = digit_carry_flag_q;
					dat_d[SLSUB_ST_Z] = zero_q;
					dat_d[SLSUB_ST_PD] = powerdown_flag_n_q;
					dat_d[SLSUB_ST_TO] = timeout_flag_n_q;
					dat_d[SLSUB_ST_SLEEP] = (state_q == SLSUB_ASLEEP);
				end
				SLSUB_REG_W: begin
					dat_d = {24'h000000, w_q};
				end
				SLSUB_REG_IRQ_STAT: begin
					dat_d = {29'h00000000, irq_stat_q};
				end
				SLSUB_REG_IRQ_MASK: begin
					dat_d = {29'h00000000, irq_mask_q};
				end
				SLSUB_REG_WDT: begin
					dat_d = {16'h0000, pre_q, watchdog_counter_q};
				end
				default: begin
					dat_d = 32'h00000000;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			dat_q <= 32'h00000000;
			ack_q <= 1'b0;
		end else begin
			dat_q <= dat_d;
			ack_q <= ack_d;
		end
	end

	// ----------------------------------------------------------------
	// power state outputs
	// ----------------------------------------------------------------
	// taken from the next state so both change on the entry and wake edges
	always_comb begin
		osc_d = (state_d != SLSUB_ASLEEP); // RL5
		sleep_d = (state_d == SLSUB_ASLEEP); // RL4
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			osc_q <= 1'b1;
			sleep_q <= 1'b0;
		end else begin
			osc_q <= osc_d;
			sleep_q <= sleep_d;
		end
	end

	// ----------------------------------------------------------------
	// output ports
	// ----------------------------------------------------------------
	assign wb_dat_o = dat_q;
	assign wb_ack_o = ack_q;
	assign irq_o = irq_q;
	assign osc_run_o = osc_q;
	assign sleep_o = sleep_q;
endmodule

// [testbench/slsub_exec_asserts.sv]
// slsub_exec_asserts: port checks for the power-down and subtract block
`timescale 1ns/100ps
module slsub_exec_asserts
	import slsub_pkg::*;
(
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic irq_o,
	input wire logic osc_run_o,
	input wire logic sleep_o
);
	logic [2:0] fl_q;
	logic [2:0] fl_d;
	logic take;
	// in-flight count, so a refused instruction write never arms the check
	assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == SLSUB_REG_INSTR
		&& wb_sel_i[1:0] == 2'b11 && !sleep_o && fl_q == 3'h0;
	assign fl_d = take ? 3'h4 : (fl_q != 3'h0) ? fl_q - 3'h1 : 3'h0;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n)
			fl_q <= 3'h0;
		else
			fl_q <= fl_d;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	property p_ack_resp;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_resp: assert property (p_ack_resp) else $error("no ack after request");
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_dat_idle;
		!wb_ack_o || wb_we_i |-> wb_dat_o == 32'h0;
	endproperty
	a_dat_idle: assert property (p_dat_idle) else $error("read data outside read ack");
	property p_sleep_entry;
		take && wb_dat_i[13:0] == SLSUB_OP_SLEEP |=> !sleep_o [*4] ##1 sleep_o;
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not in fourth phase");
	property p_osc_off;
		osc_run_o == !sleep_o;
	endproperty
	a_osc_off: assert property (p_osc_off) else $error("oscillator runs while asleep");
	property p_sleep_hold;
		sleep_o && !(wb_cyc_i && wb_we_i) |=> sleep_o;
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("sleep left without wake");
	property p_flags;
		wb_ack_o && !wb_we_i && wb_adr_i == SLSUB_REG_STATUS && sleep_o && $past(sleep_o)
			|-> wb_dat_o[5:3] == 3'b110;
	endproperty
	a_flags: assert property (p_flags) else $error("status flags wrong while asleep");
	c_sleep: cover property ($rose(sleep_o));
	c_wake: cover property ($fell(sleep_o));
	c_irq: cover property ($rose(irq_o));
endmodule
bind slsub_exec slsub_exec_asserts u_slsub_exec_asserts (.sys_clk(sys_clk), .reset_n(reset_n),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.irq_o(irq_o), .osc_run_o(osc_run_o), .sleep_o(sleep_o));

// [testbench/tb_slsub_exec.sv]
// tb_slsub_exec: register-level bench for the power-down and subtract block
`timescale 1ns/100ps
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
	$display("mismatch %s exp %h got %h", n, e, a); end end
module tb_slsub_exec
	import slsub_pkg::*;
;
	logic sys_clk = 0;
	logic reset_n = 0;
	logic cyc = 0;
	logic stb = 0;
	logic we = 0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hf;
	logic [3:0] bs = 4'hf;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic [31:0] v;
	logic ack, irq, osc, slp;
	logic [7:0] lw;
	logic [2:0] fl;
	int fail_count = 0;
	int n_compared = 0;
	always #4 sys_clk = ~sys_clk;
	slsub_exec u_slsub_exec (.sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq), .osc_run_o(osc), .sleep_o(slp));
	// ------------------------------------------------------------
	// bus tasks
	// ------------------------------------------------------------
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= bs;
		wdat <= d;
		@(posedge sys_clk);
		// only the watchdog ends a wait that never sees ack
		while (ack !== 1'b1) @(posedge sys_clk);
		v = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		`CHK(nm, e, v)
	endtask
	// x selects the second encoding of the subtract opcode
	task automatic sub(input logic [7:0] k, input logic [7:0] w, input logic x);
		bus(1'b1, SLSUB_REG_W, {24'h0, w});
		bus(1'b1, SLSUB_REG_INSTR, {18'h0, 5'b11110, x, k});
		repeat (4) @(posedge sys_clk);
		lw = k - w;
		fl = {lw == 8'h00, k[3:0] >= w[3:0], k >= w};
		rdchk("w", SLSUB_REG_W, {24'h0, lw});
		rdchk("status", SLSUB_REG_STATUS, {27'h0, 2'b11, fl});
	endtask
	task automatic finish_test;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#20000;
		fail_count++;
		finish_test;
	end
	initial begin
		repeat (5) @(posedge sys_clk);
		reset_n <= 1'b1;
		rdchk("status", SLSUB_REG_STATUS, 32'h18);
		rdchk("unmapped", 8'h1c, 32'h0);
		sub(8'h02, 8'h01, 1'b0);
		sub(8'h02, 8'h02, 1'b1);
		sub(8'h10, 8'h01, 1'b0);
		sub(8'h02, 8'h03, 1'b1);
		`CHK("irq masked", 1'b0, irq)
		bus(1'b1, SLSUB_REG_IRQ_MASK, 32'h3);
		repeat (2) @(posedge sys_clk);
		`CHK("irq", 1'b1, irq)
		rdchk("irq stat", SLSUB_REG_IRQ_STAT, 32'h2);
		bus(1'b1, SLSUB_REG_IRQ_STAT, 32'h2);
		repeat (2) @(posedge sys_clk);
		`CHK("irq cleared", 1'b0, irq)
		// ticks first, so clearing the prescaler is visible
		repeat (3) bus(1'b1, SLSUB_REG_CTRL, 32'h2);
		rdchk("wdt", SLSUB_REG_WDT, 32'h0300);
		bus(1'b1, SLSUB_REG_INSTR, {18'h0, SLSUB_OP_SLEEP});
		repeat (4) @(posedge sys_clk);
		`CHK("sleep", 1'b1, slp)
		`CHK("osc", 1'b0, osc)
		`CHK("irq sleep", 1'b1, irq)
		rdchk("status", SLSUB_REG_STATUS, {26'h0, 3'b110, fl});
		rdchk("wdt", SLSUB_REG_WDT, 32'h0);
		bus(1'b1, SLSUB_REG_INSTR, 32'h3c55);
		repeat (5) @(posedge sys_clk);
		rdchk("w halted", SLSUB_REG_W, {24'h0, lw});
		`CHK("osc", 1'b0, osc)
		bus(1'b1, SLSUB_REG_CTRL, 32'h1);
		@(posedge sys_clk);
		`CHK("awake", 1'b0, slp)
		`CHK("osc run", 1'b1, osc)
		rdchk("status", SLSUB_REG_STATUS, {26'h0, 3'b010, fl});
		// an opcode owned by another block only raises its event
		bus(1'b1, SLSUB_REG_INSTR, 32'h0);
		repeat (4) @(posedge sys_clk);
		rdchk("irq stat bad", SLSUB_REG_IRQ_STAT, 32'h5);
		rdchk("w kept", SLSUB_REG_W, {24'h0, lw});
		// one byte lane is not enough for an instruction write
		bs = 4'h1;
		bus(1'b1, SLSUB_REG_INSTR, {18'h0, SLSUB_OP_SLEEP});
		bs = 4'hf;
		repeat (4) @(posedge sys_clk);
		`CHK("sel refused", 1'b0, slp)
		finish_test;
	end
endmodule
